// File: hdl/bds_pkg.sv
// Constants, field layout and carriers of the backup domain supply control.
// Assumes one 50 MHz clock and a register port driven by logic on that clock.
// Summary of operation
// R1: Backup power loss resets the domain; main-side resets do not.
// R2: Domain resets only from backup power-on reset or a software reset request.
// R3: Reset-pending reads one during a requested reset, zero once finished.
// R4: Software polls reset-pending to zero before writing any domain register.
// R5: Software restarts the low-speed internal oscillator after a domain reset.
// R6: Supply enable output comes out of reset high.
// R7: Driving supply enable low switches the external regulator off.
// R8: While supply enable is low, wake pin high or clock wake sets it high.
// R9: Control writes are ignored until the unlock key is written first.
// R10: Key 0x3A unlocks, stopping automatic control; output acts as plain pin.
// R11: Any non-key value in the key field relocks and enables the controller.
// R12: Software enables by unlock, set on bit, then relock with non-key value.
// R13: Always-enable holds the output high until domain reset or power loss.
// R14: Clearing the on bit while unlocked drives supply enable low.
// R15: Relocking re-enables output; stay unlocked to keep the supply off.
// R16: Wake pin acts only on a high level, never on a low level.
// R17: Shared hibernate wake pin must be configured active high by software.
// R18: Clock wake comes from two alarms or a selected period rollover.
// R19: Sixteen 32-bit retention words, 64 bytes, kept until backup power loss or a domain reset clears them.
// R20: Retention words stay readable after hibernate wake and main reset.
// R21: Writing the reset request starts a reset; pending self-clears when done.
package bds_pkg;

    localparam int          ADDR_W      = 7;
    localparam int          NUM_RET     = 16;
    localparam logic [6:0]  CTRL_OFF    = 7'h00;
    localparam logic [6:0]  SUPPLY_OFF  = 7'h04;
    localparam logic [6:0]  WAKE_OFF    = 7'h08;
    localparam logic [6:0]  STATUS_OFF  = 7'h0c;
    localparam logic [6:0]  RET_BASE    = 7'h40;

    localparam int          RST_REQ_BIT = 0;
    localparam int          KEY_LSB     = 0;
    localparam logic [7:0]  UNLOCK_KEY  = 8'h3a;
    localparam int          ON_BIT      = 8;
    localparam int          ALWAYS_BIT  = 9;
    localparam int          WK_PIN_BIT  = 0;
    localparam int          WK_ALM_LSB  = 1;
    localparam int          WK_ROLL_LSB = 3;

    localparam logic        SUPPLY_EN_RST = 1'b1;
    localparam logic [6:0]  WAKE_CFG_RST  = 7'h00;

    // Completion time of a requested reset, in slow backup clock periods.
    localparam int          SLOW_CLK_HZ    = 32768;
    localparam int          REF_CLK_HZ     = 50000000;
    localparam int          DOM_RST_SLOW   = 4;
    localparam int          DOM_RST_CYCLES =
        (DOM_RST_SLOW * REF_CLK_HZ + SLOW_CLK_HZ - 1) / SLOW_CLK_HZ;

    typedef enum logic [1:0] {
        DOM_RUN = 2'b01,
        DOM_RST = 2'b10
    } bds_dom_e;

    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
    } bds_bus_s;

    typedef struct packed {
        logic [1:0] alarm;
        logic [3:0] roll;
    } bds_clk_wake_s;

    typedef struct packed {
        bds_dom_e                  fsm;
        logic [15:0]               cnt;
        logic                      unlocked;
        logic                      on;
        logic                      always_on;
        logic                      out;
        logic [6:0]                wake_cfg;
        logic [1:0]                sync;
        logic [31:0]               rdata;
        logic [NUM_RET-1:0][31:0]  ret;
    } bds_state_s;

endpackage

// File: hdl/bds_supply_ctl.sv
// Backup domain supply controller with domain reset and retention words.
// Assumes resetn is the backup power-on reset and the wake pin is asynchronous.
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps

module bds_supply_ctl #(
    parameter int RST_CYCLES = bds_pkg::DOM_RST_CYCLES
) (
    input  wire logic                 ref_clk,
    input  wire logic                 resetn,
    input  wire bds_pkg::bds_bus_s    bus,
    input  wire bds_pkg::bds_clk_wake_s clk_wake,
    input  wire logic                 wake_pin,
    output logic [31:0]               rdata,
    output logic                      supply_en,
    output logic                      reset_pending
);

    bds_pkg::bds_state_s s_reg;
    bds_pkg::bds_state_s s_next;
    logic                wake_req;

    // True when the byte address falls in the retention window.
    function automatic logic is_ret(input logic [bds_pkg::ADDR_W-1:0] a);
        is_ret = (a[6] == bds_pkg::RET_BASE[6]);
    endfunction

    // Word index inside the retention window.
    function automatic logic [3:0] ret_idx(input logic [bds_pkg::ADDR_W-1:0] a);
        ret_idx = a[5:2];
    endfunction

    // Wake sources are gated by their enables; the pin only counts when high,
    // since a low level is the idle state of a pulled-down button. [R16] [R18]
    always_comb begin
        wake_req = (s_reg.wake_cfg[bds_pkg::WK_PIN_BIT] & s_reg.sync[1])
                 | (|(s_reg.wake_cfg[bds_pkg::WK_ALM_LSB +: 2] & clk_wake.alarm))
                 | (|(s_reg.wake_cfg[bds_pkg::WK_ROLL_LSB +: 4] & clk_wake.roll));
    end

    // Next state of the whole domain.
    always_comb begin
        s_next       = s_reg;
        s_next.sync  = {s_reg.sync[0], wake_pin};
        s_next.rdata = 32'h0000_0000;

        case (s_reg.fsm)
            bds_pkg::DOM_RUN: begin
                if (bus.wr) begin
                    // A reset request starts the slow reset sequence. [R2] [R21]
                    if (bus.addr == bds_pkg::CTRL_OFF) begin
                        if (bus.wdata[bds_pkg::RST_REQ_BIT]) begin
                            s_next.fsm = bds_pkg::DOM_RST;
                            s_next.cnt = 16'(RST_CYCLES);
                        end
                    end
                    // Key field first; other fields count only when the
                    // controller was already unlocked. [R9]
                    if (bus.addr == bds_pkg::SUPPLY_OFF) begin
                        if (bus.wdata[bds_pkg::KEY_LSB +: 8] == bds_pkg::UNLOCK_KEY) begin
                            s_next.unlocked = 1'b1; // [R10]
                            if (s_reg.unlocked) begin
                                s_next.on = bus.wdata[bds_pkg::ON_BIT];
                                if (bus.wdata[bds_pkg::ALWAYS_BIT]) begin
                                    s_next.always_on = 1'b1; // [R13]
                                end
                                s_next.out = bus.wdata[bds_pkg::ON_BIT]; // [R14] [R7]
                            end
                        end else begin
                            // Relock turns the regulator back on. [R11] [R15]
                            s_next.unlocked = 1'b0;
                            s_next.on       = 1'b1;
                            s_next.out      = 1'b1;
                        end
                    end
                    if (bus.addr == bds_pkg::WAKE_OFF) begin
                        s_next.wake_cfg = bus.wdata[6:0];
                    end
                    // Retention words change on a software write; a domain reset clears them. [R19]
                    if (is_ret(bus.addr)) begin
                        s_next.ret[ret_idx(bus.addr)] = bus.wdata;
                    end
                end
            end
            bds_pkg::DOM_RST: begin
                // Writes are dropped while the slow logic is still resetting.
                if (s_reg.cnt > 16'h0001) begin
                    s_next.cnt = s_reg.cnt - 16'h0001;
                end else begin
                    s_next.fsm       = bds_pkg::DOM_RUN;
                    s_next.cnt       = 16'h0000;
                    s_next.unlocked  = 1'b0;
                    s_next.on        = 1'b1;
                    s_next.always_on = 1'b0; // [R13]
                    s_next.out       = bds_pkg::SUPPLY_EN_RST;
                    s_next.wake_cfg  = bds_pkg::WAKE_CFG_RST;
                    s_next.ret       = '0;
                end
            end
            default: begin
                s_next.fsm = bds_pkg::DOM_RUN;
            end
        endcase

        // A wake seen in the same cycle as a disable write wins. [R8]
        if (!s_next.out && wake_req) begin
            s_next.out = 1'b1;
            s_next.on  = 1'b1;
        end

        // Always-enable overrides any later disable attempt. [R13]
        if (s_next.always_on) begin
            s_next.out = 1'b1;
        end

        // Read data stand for exactly one cycle after the strobe.
        if (bus.rd) begin
            if (bus.addr == bds_pkg::CTRL_OFF) begin
                s_next.rdata[bds_pkg::RST_REQ_BIT] = (s_reg.fsm == bds_pkg::DOM_RST); // [R3]
            end else if (bus.addr == bds_pkg::SUPPLY_OFF) begin
                s_next.rdata[bds_pkg::KEY_LSB +: 8] =
                    s_reg.unlocked ? bds_pkg::UNLOCK_KEY : 8'h00;
                s_next.rdata[bds_pkg::ON_BIT]     = s_reg.on;
                s_next.rdata[bds_pkg::ALWAYS_BIT] = s_reg.always_on;
            end else if (bus.addr == bds_pkg::WAKE_OFF) begin
                s_next.rdata[6:0] = s_reg.wake_cfg;
            end else if (bus.addr == bds_pkg::STATUS_OFF) begin
                s_next.rdata[0] = (s_reg.fsm == bds_pkg::DOM_RST);
                s_next.rdata[1] = s_reg.unlocked;
                s_next.rdata[2] = s_reg.out;
                s_next.rdata[3] = s_reg.always_on;
                s_next.rdata[4] = s_reg.sync[1];
            end else if (is_ret(bus.addr)) begin
                s_next.rdata = s_reg.ret[ret_idx(bus.addr)]; // [R20]
            end
        end
    end

    // Backup power-on reset and a requested domain reset clear the domain; main-side resets never
    // reach this process, so state survives them. [R1] [R2] [R6]
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_reg           <= '0;
            s_reg.fsm       <= bds_pkg::DOM_RUN;
            s_reg.on        <= 1'b1;
            s_reg.out       <= bds_pkg::SUPPLY_EN_RST;
            s_reg.wake_cfg  <= bds_pkg::WAKE_CFG_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs come straight from the state register.
    assign rdata         = s_reg.rdata;
    assign supply_en     = s_reg.out;
    assign reset_pending = s_reg.fsm[1];

endmodule

// File: sim/bds_supply_ctl_chk.sv
// Port checker of the backup domain supply controller.
// Assumes one clock and resetn as the only asynchronous reset of the domain.
`timescale 1ns/1ps
module bds_supply_ctl_chk #(parameter int RST_CYCLES = bds_pkg::DOM_RST_CYCLES) (
    input wire logic                   ref_clk,
    input wire logic                   resetn,
    input wire bds_pkg::bds_bus_s      bus,
    input wire bds_pkg::bds_clk_wake_s clk_wake,
    input wire logic                   wake_pin,
    input wire logic [31:0]            rdata,
    input wire logic                   supply_en,
    input wire logic                   reset_pending
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    wire         sup_wr = bus.wr && bus.addr == bds_pkg::SUPPLY_OFF;
    wire         key_w  = bus.wdata[7:0] == bds_pkg::UNLOCK_KEY;
    logic [15:0] pend_n;
    // Counts the pending run, since a repetition cannot take the parameter.
    always_ff @(posedge ref_clk or negedge resetn)
        if (!resetn) pend_n <= '0;
        else pend_n <= reset_pending ? pend_n + 16'h1 : 16'h0;
    sequence unlock_s; sup_wr && key_w && !reset_pending; endsequence
    sequence always_s; sup_wr && key_w && bus.wdata[bds_pkg::ALWAYS_BIT]; endsequence
    rdata_idle_a: assert property (!bus.rd |=> rdata == 32'h0)
        else $error("read data not zero outside a read");
    pend_start_a: assert property (bus.wr && bus.addr == bds_pkg::CTRL_OFF && bus.wdata[0]
        && !reset_pending |=> reset_pending) else $error("reset request not pending");
    pend_len_a: assert property ($fell(reset_pending) |-> pend_n == RST_CYCLES)
        else $error("pending run has wrong length");
    pend_cap_a: assert property (pend_n <= RST_CYCLES) else $error("pending too long");
    rise_cause_a: assert property ($rose(supply_en) |-> $past(bus.wr) || |$past(clk_wake)
        || $past(wake_pin, 2) || $past(wake_pin, 3) || $past(wake_pin, 4) || $past(reset_pending))
        else $error("supply enable rose without cause");
    fall_cause_a: assert property ($fell(supply_en) |-> $past(sup_wr) && $past(key_w)
        && !$past(bus.wdata[8])) else $error("supply enable fell without disable");
    relock_on_a: assert property (sup_wr && !key_w && !reset_pending |=> supply_en)
        else $error("relock left supply off");
    always_hold_a: assert property (unlock_s ##1 always_s |=> supply_en [*8])
        else $error("always enable did not hold");
    status_rd_a: assert property (bus.rd && bus.addr == bds_pkg::STATUS_OFF |=> rdata[2] ==
        $past(supply_en) && rdata[0] == $past(reset_pending)) else $error("bad status");
endmodule

// File: sim/bds_pwr_model.sv
// Model of the wake button and the external regulator.
// Assumes the bench presses the button through a level on press.
`timescale 1ns/1ps
module bds_pwr_model (
    input  wire logic ref_clk,
    input  wire logic supply_en,
    input  wire logic press,
    input  wire logic domain_rst,
    input  wire logic osc_en,
    output logic      wake_pin,
    output logic      main_on,
    output logic      osc_ok
);
    logic             osc_q = 1'b1;
    // The pin has a pull-down, so a released button reads low, never a stale level.
    assign wake_pin = press;
    // The regulator follows its active-high enable one cycle late.
    always_ff @(posedge ref_clk) main_on <= supply_en;
    // A domain reset leaves the slow oscillator stale until it is switched off and on again.
    always_ff @(posedge ref_clk) begin
        osc_q  <= osc_en;
        osc_ok <= domain_rst ? 1'b0 : (osc_ok | (osc_en & ~osc_q));
    end
endmodule

// File: sim/bds_supply_ctl_tb_top.sv
// Bench of the supply controller: retention words, lock, wake sources, domain reset.
// Assumes the checker is bound below and a short domain reset count.
`timescale 1ns/1ps
module bds_supply_ctl_tb_top;
    localparam int          RST_N = 8;
    logic                   ref_clk = 1'b0, resetn = 1'b0, press = 1'b0, rd_q = 1'b0;
    logic                   wake_pin, supply_en, reset_pending, main_on, osc_ok;
    logic                   osc_en = 1'b1, rd_st_q = 1'b0;
    logic [2:0]             pin_q[$];
    logic [31:0]            rdata, ret[16], exp_q[$];
    bds_pkg::bds_bus_s      bus = '0;
    bds_pkg::bds_clk_wake_s cw = '0;
    int                     fail_count = 0, compares = 0, cyc_n = 0;
    integer                 seed = 2662;
    bds_supply_ctl #(.RST_CYCLES(RST_N)) i_bds_supply_ctl (.ref_clk(ref_clk), .resetn(resetn),
        .bus(bus), .clk_wake(cw), .wake_pin(wake_pin), .rdata(rdata), .supply_en(supply_en),
        .reset_pending(reset_pending));
    bds_pwr_model i_bds_pwr_model (.ref_clk(ref_clk), .supply_en(supply_en), .press(press),
        .domain_rst(reset_pending), .osc_en(osc_en), .wake_pin(wake_pin), .main_on(main_on),
        .osc_ok(osc_ok));
    initial forever #10 ref_clk = ~ref_clk;
    task automatic cyc(input logic r, w, input logic [6:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        bus <= '{r, w, a, d};
    endtask
    task automatic rd(input logic [6:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        cyc(1'b1, 1'b0, a, 32'h0);
    endtask
    task automatic wr(input logic [6:0] a, input logic [31:0] d); cyc(1'b0, 1'b1, a, d); endtask
    task automatic idle(input int n); repeat (n) cyc(1'b0, 1'b0, 7'h0, 32'h0); endtask
    task automatic wsup(input logic [31:0] d); wr(bds_pkg::SUPPLY_OFF, d); endtask
    task automatic st(input logic [31:0] e);
        pin_q.push_back({e[2], e[2], e[0]});
        rd(bds_pkg::STATUS_OFF, e);
    endtask
    task automatic pulse(input int k);
        idle(1);
        cw <= 6'(1 << k);
        idle(1);
        cw <= '0;
    endtask
    task automatic chk_rd(input logic [31:0] e);
        compares++;
        if (rdata !== e) begin
            fail_count++;
            $display("FAIL t=%0t got %h exp %h", $time, rdata, e);
        end
    endtask
    // Pins as {regulator, supply enable, reset pending}.
    task automatic chk_pin(input logic [2:0] e);
        compares++;
        if ({main_on, supply_en, reset_pending} !== e) begin
            fail_count++;
            $display("FAIL t=%0t pins got %h exp %h", $time, {main_on, supply_en, reset_pending}, e);
        end
    endtask
    task automatic chk_bit(input logic g, input logic e);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("FAIL t=%0t osc got %h exp %h", $time, g, e);
        end
    endtask
    // Firmware polls pending to zero before touching the domain; one read every two cycles.
    task automatic poll_pend;
        int k;
        k = 0;
        do begin
            k++;
            rd(bds_pkg::CTRL_OFF, {31'h0, (2 * k - 1 < RST_N)});
            idle(1);
            @(negedge ref_clk);
        end while (rdata[0] && k < RST_N);
    endtask
    task automatic done(input string s); idle(2); $display("test %0s done", s); endtask
    task automatic complete_run;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Read answers are taken mid-cycle against the oldest note, where they have settled.
    always @(posedge ref_clk) rd_q <= bus.rd;
    always @(negedge ref_clk) if (rd_q) chk_rd(exp_q.pop_front());
    // Pins are compared in the cycle after a status read, where the regulator has caught up.
    always @(posedge ref_clk) rd_st_q <= bus.rd && bus.addr == bds_pkg::STATUS_OFF;
    always @(negedge ref_clk) if (rd_st_q) chk_pin(pin_q.pop_front());
    // A hang ends the run as a failure.
    always @(posedge ref_clk) begin
        cyc_n++;
        if (cyc_n == 2000) begin
            fail_count++;
            complete_run();
        end
    end
    // Main sequence: each block of calls is one test.
    initial begin
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        st(32'h4);
        rd(7'h20, 32'h0);
        done("reset");
        for (int i = 0; i < 16; i++) begin
            ret[i] = $random(seed);
            wr(7'(bds_pkg::RET_BASE + 4 * i), ret[i]);
        end
        for (int i = 0; i < 16; i++) rd(7'(bds_pkg::RET_BASE + 4 * i), ret[i]);
        done("retention");
        wsup(32'h3a);
        st(32'h6);
        wsup(32'h3a);
        st(32'h2);
        rd(bds_pkg::SUPPLY_OFF, 32'h3a);
        done("lock");
        wr(bds_pkg::WAKE_OFF, 32'h1);
        idle(4);
        st(32'h2);
        press <= 1'b1;
        idle(5);
        st(32'h16);
        press <= 1'b0;
        done("wake pin");
        for (int k = 0; k < 6; k++) begin
            int b;
            b = (k < 4) ? 3 + k : k - 3;
            wsup(32'h3a);
            wr(bds_pkg::WAKE_OFF, 32'h7e ^ (32'h1 << b));
            pulse(k);
            st(32'h2);
            wr(bds_pkg::WAKE_OFF, 32'h1 << b);
            pulse(k);
            st(32'h6);
        end
        wsup(32'h3a);
        wsup(32'h13a);
        st(32'h6);
        wsup(32'h100);
        st(32'h4);
        rd(bds_pkg::RET_BASE, ret[0]);
        done("clock wake");
        wsup(32'h3a);
        wsup(32'h23a);
        wsup(32'h3a);
        st(32'he);
        done("always");
        wr(bds_pkg::CTRL_OFF, 32'h1);
        rd(bds_pkg::CTRL_OFF, 32'h1);
        poll_pend();
        chk_bit(osc_ok, 1'b0);
        idle(1);
        osc_en <= 1'b0;
        idle(1);
        osc_en <= 1'b1;
        idle(2);
        @(negedge ref_clk);
        chk_bit(osc_ok, 1'b1);
        rd(bds_pkg::CTRL_OFF, 32'h0);
        st(32'h4);
        rd(bds_pkg::RET_BASE, 32'h0);
        wr(bds_pkg::RET_BASE, 32'h5a);
        rd(bds_pkg::RET_BASE, 32'h5a);
        done("domain reset");
        complete_run();
    end
endmodule
bind bds_supply_ctl bds_supply_ctl_chk #(.RST_CYCLES(RST_CYCLES)) i_bds_supply_ctl_chk (
    .ref_clk(ref_clk), .resetn(resetn), .bus(bus), .clk_wake(clk_wake), .wake_pin(wake_pin),
    .rdata(rdata), .supply_en(supply_en), .reset_pending(reset_pending));
